// [spi_peer.sv]
// Far-side SPI party: frames as master, replies as slave
`timescale 1ns/10ps
`default_nettype none
module spi_peer (
   output logic      sck,
   output logic      mosi,
   output logic      sel,
   output logic      miso,
   input  wire logic sck_line,
   input  wire logic mosi_line,
   input  wire logic miso_line
);
   logic [7:0] slave_tx;
   logic [7:0] slave_rx;
   logic [7:0] master_rx;
   initial begin
      {sck, mosi, sel, miso} = 4'h2;
      {slave_tx, slave_rx, master_rx} = '0;
   end
   // Clock idles low between frames; mosi flips so no stale bit lingers
   task automatic xfer(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         mosi = b[7 - i];
         #80 sck = 1'b1;
         master_rx = {master_rx[6:0], miso_line};
         #80 sck = 1'b0;
      end
      mosi = ~mosi;
   endtask : xfer
   task automatic load(input logic [7:0] b);
      slave_tx = b;
      miso = b[7];
   endtask : load
   always @(posedge sck_line) slave_rx <= {slave_rx[6:0], mosi_line};
   always @(negedge sck_line) begin
      slave_tx = {slave_tx[6:0], ~slave_tx[7]};
      miso = slave_tx[7];
   end
endmodule : spi_peer
`default_nettype wire

// [spi_port.sv]
// SPI port pin, select-mode and shift logic with its receive FIFO
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module spi_rx_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned PW = $clog2(DEPTH);

   typedef struct packed {
      logic [PW-1:0] wptr;
      logic [PW-1:0] rptr;
      logic [PW:0]   fill;
   } fifo_state_t;

   fifo_state_t      s;
   fifo_state_t      next_s;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   assign in_ready  = (s.fill != (PW+1)'(DEPTH));
   assign out_valid = (s.fill != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[s.rptr];

   always_comb begin
      next_s = s;
      if (push) begin
         next_s.wptr = (s.wptr == PW'(DEPTH - 1)) ? '0 : s.wptr + 1'b1;
      end
      if (pop) begin
         next_s.rptr = (s.rptr == PW'(DEPTH - 1)) ? '0 : s.rptr + 1'b1;
      end
      next_s.fill = s.fill + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Storage needs no reset; out_valid guards stale words
   always_ff @(posedge clock) begin
      if (push) begin
         mem[s.wptr] <= in_data;
      end
   end
endmodule : spi_rx_fifo

////////////////////////////////////////////////////////////////////////////////
module spi_port
   import spi_port_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   // Control and status
   input  wire logic [1:0] select_pin_mode,
   input  wire logic       cfg_write,
   input  wire logic       cfg_port_enable,
   input  wire logic       cfg_master_enable,
   output logic            port_enable_bit,
   output logic            master_enable_bit,
   output logic            mode_fault_flag,
   input  wire logic       clear_mode_fault,
   output logic            transfer_done_flag,
   input  wire logic       clear_transfer_done,
   output logic            rx_overrun_flag,
   input  wire logic       clear_rx_overrun,
   // Transmit byte and receive stream
   input  wire logic       tx_valid,
   output logic            tx_ready,
   input  wire logic [7:0] tx_data,
   output logic            rx_valid,
   input  wire logic       rx_ready,
   output logic      [7:0] rx_data,
   // Pins
   input  wire logic       mosi_in,
   output logic            mosi_out,
   output logic            mosi_oe,
   input  wire logic       miso_in,
   output logic            miso_out,
   output logic            miso_oe,
   input  wire logic       sck_in,
   output logic            sck_out,
   output logic            sck_oe,
   input  wire logic       select_in,
   output logic            select_out,
   output logic            select_oe,
   output logic            select_routed
);
   port_state_t s;
   port_state_t next_s;
   logic        fifo_in_ready;

   // Selection as a slave for the current select mode
   function automatic logic slave_selected(input logic [1:0] mode, input logic sel);
      slave_selected = (mode == MODE_SELECT_IN) ? !sel : 1'b1; // [R9] [R10] [R16]
   endfunction : slave_selected

   logic master;
   logic slave_active;
   logic four_wire_in;
   logic sck_rise;
   logic sck_fall;
   logic sel_fall;
   logic byte_done;

   assign master       = s.port_en && s.master_en;
   assign four_wire_in = (select_pin_mode == MODE_SELECT_IN);
   assign slave_active = s.port_en && !s.master_en
                         && slave_selected(select_pin_mode, s.sel_sync); // [R8] [R16]
   assign sel_fall     = s.sel_prev && !s.sel_sync; // [R19]

   always_comb begin
      sck_rise = 1'b0;
      sck_fall = 1'b0;
      if (master) begin
         // [R7]
         if (s.busy && s.div == SCK_DIV_LAST) begin
            sck_rise = !s.sck;
            sck_fall = s.sck;
         end
      end else if (slave_active) begin
         sck_rise = s.sck_sync && !s.sck_prev;
         sck_fall = !s.sck_sync && s.sck_prev;
      end
   end

   assign byte_done = sck_fall && (s.count == LAST_BIT);

   always_comb begin
      next_s = s;
      next_s.push = 1'b0;
      // Two flops on every outside input before use
      next_s.sck_meta  = sck_in;
      next_s.sck_sync  = s.sck_meta;
      next_s.sck_prev  = s.sck_sync;
      next_s.mosi_meta = mosi_in;
      next_s.mosi_sync = s.mosi_meta;
      next_s.miso_meta = miso_in;
      next_s.miso_sync = s.miso_meta;
      next_s.sel_meta  = select_in; // [R19]
      next_s.sel_sync  = s.sel_meta;
      next_s.sel_prev  = s.sel_sync;
      next_s.sel_drive = select_pin_mode[0]; // [R12]

      if (cfg_write) begin
         next_s.port_en   = cfg_port_enable;
         next_s.master_en = cfg_master_enable;
      end
      if (clear_mode_fault) begin
         next_s.fault = 1'b0;
      end
      if (clear_transfer_done) begin
         next_s.done = 1'b0;
      end
      if (clear_rx_overrun) begin
         next_s.overrun = 1'b0;
      end

      // Transmit holding buffer
      if (tx_valid && !s.tx_full) begin
         next_s.tx_buf  = tx_data;
         next_s.tx_full = 1'b1;
      end
      if (!s.loaded && s.tx_full && !s.busy && s.count == '0) begin
         next_s.shift   = s.tx_buf;
         next_s.loaded  = 1'b1;
         next_s.tx_full = 1'b0;
      end

      // Master starts only with room for the answer byte
      if (master && !s.busy && s.loaded && fifo_in_ready) begin
         next_s.busy = 1'b1;
         next_s.div  = '0;
      end
      if (master && s.busy) begin
         next_s.div = (s.div == SCK_DIV_LAST) ? '0 : s.div + 4'h1;
         if (s.div == SCK_DIV_LAST) begin
            next_s.sck = !s.sck;
         end
      end

      if (sck_rise) begin
         next_s.sample = master ? s.miso_sync : s.mosi_sync; // [R4] [R1]
      end
      if (sck_fall) begin
         next_s.shift = {s.shift[6:0], s.sample}; // [R2]
         next_s.count = s.count + 3'h1;
      end
      if (byte_done) begin
         // [R18]
         next_s.done    = 1'b1;
         next_s.loaded  = 1'b0;
         next_s.busy    = 1'b0;
         next_s.rx_byte = {s.shift[6:0], s.sample};
         if (fifo_in_ready) begin
            next_s.push = 1'b1;
         end else begin
            next_s.overrun = 1'b1;
         end
      end

      // Slave counter restarts on a select falling edge
      if (!s.port_en || (!s.master_en && four_wire_in && sel_fall)) begin
         next_s.count = '0; // [R17]
         next_s.sck   = 1'b0;
         next_s.busy  = 1'b0;
      end

      // Another master claims the bus; fault beats a same-cycle config write
      if (master && four_wire_in && !s.sel_sync) begin
         next_s.master_en = 1'b0; // [R11] [R15]
         next_s.port_en   = 1'b0;
         next_s.fault     = 1'b1;
         next_s.busy      = 1'b0;
         next_s.sck       = 1'b0;
         next_s.count     = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   spi_rx_fifo #(
      .WIDTH (WORD_BITS),
      .DEPTH (RX_FIFO_DEPTH)
   ) rx_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (s.push),
      .in_ready  (fifo_in_ready),
      .in_data   (s.rx_byte),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_data)
   );

   assign tx_ready           = !s.tx_full;
   assign port_enable_bit    = s.port_en;
   assign master_enable_bit  = s.master_en;
   assign mode_fault_flag    = s.fault;
   assign transfer_done_flag = s.done;
   assign rx_overrun_flag    = s.overrun;

   assign mosi_out = s.shift[7]; // [R3]
   assign mosi_oe  = master; // [R1]
   assign sck_out  = s.sck;
   assign sck_oe   = master; // [R7]
   assign miso_out = s.shift[7]; // [R6]
   // Unselected or disabled slave releases the shared line
   assign miso_oe  = slave_active; // [R4] [R5] [R6]
   assign select_out    = s.sel_drive;
   assign select_oe     = select_pin_mode[1]; // [R12]
   assign select_routed = (select_pin_mode != MODE_THREE_WIRE); // [R14]
endmodule : spi_port

`default_nettype wire

// [spi_port_checker.sv]
// Pin-drive and select-mode assertions for the SPI port
`timescale 1ns/10ps
`default_nettype none
module spi_port_checker (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic [1:0] select_pin_mode,
   input wire logic       port_enable_bit,
   input wire logic       master_enable_bit,
   input wire logic       mode_fault_flag,
   input wire logic       select_in,
   input wire logic       mosi_oe,
   input wire logic       miso_oe,
   input wire logic       sck_oe,
   input wire logic       select_out,
   input wire logic       select_oe,
   input wire logic       select_routed
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire logic on_master = port_enable_bit && master_enable_bit;
   wire logic sel_input = select_pin_mode == 2'h1;

   a_mosi_drive: assert property (mosi_oe == on_master)
      else $error("bad mosi_oe");
   a_sck_drive: assert property (sck_oe == on_master)
      else $error("bad sck_oe");
   a_miso_off: assert property (!port_enable_bit || master_enable_bit |-> !miso_oe)
      else $error("miso driven while off or master");
   // Sync delay is two flops, so four high samples must have landed
   a_miso_unsel: assert property ((sel_input && select_in) [*4] |-> !miso_oe)
      else $error("miso driven while unselected");
   a_sel_dir: assert property (select_oe == select_pin_mode[1])
      else $error("bad select_oe");
   a_sel_level: assert property (select_pin_mode[1] |=> select_out == $past(select_pin_mode[0]))
      else $error("bad select_out");
   a_sel_route: assert property (select_routed == (select_pin_mode != 2'h0))
      else $error("bad select_routed");
   a_fault_abort: assert property ((sel_input && on_master && !select_in) [*3]
      |-> ##[1:3] (!port_enable_bit && !master_enable_bit && mode_fault_flag))
      else $error("no mode fault");
endmodule : spi_port_checker

////////////////////////////////////////////////////////////////////////////////
bind spi_port spi_port_checker spi_port_checker_i (
   .clock, .rst, .select_pin_mode, .port_enable_bit, .master_enable_bit, .mode_fault_flag,
   .select_in, .mosi_oe, .miso_oe, .sck_oe, .select_out, .select_oe, .select_routed);
`default_nettype wire

// [spi_port_pkg.sv]
// Constants and state types shared by the SPI pin and select logic
// Contract
// [R1] Master-out line is driven as master, read as an input as slave.
// [R2] Both data lines shift most-significant bit first in every mode.
// [R3] As master, master-out carries the shift register top bit, 3- or 4-wire.
// [R4] Master-in is sampled as master and driven as slave.
// [R5] Master-in floats when disabled or an unselected 4-wire slave.
// [R6] A 3-wire slave always drives master-in from the shift register top bit.
// [R7] Master generates the serial clock; slave takes it from the external master.
// [R8] An unselected 4-wire slave ignores all serial clock activity.
// [R9] Select mode 00: 3-wire, select pin unused, slave always selected.
// [R10] Select mode 01: select pin is an input choosing slave selection.
// [R11] Master in mode 01: select falling low disables the master function.
// [R12] Select mode 1x: select pin is an output at the mode low bit level.
// [R13] Software should pick select-output mode only when configured as master.
// [R14] Select signal is unrouted in 3-wire modes, routed to a pin otherwise.
// [R15] Multi-master low select clears master and port enables, sets mode fault.
// [R16] A 4-wire slave is active while select is low, idle while high.
// [R17] A select falling edge resets the 4-wire slave bit counter.
// [R18] Slave sets transfer done and buffers the byte after 8 bits.
// [R19] Select input is synchronised before its edges or level are used.
package spi_port_pkg;
   localparam int unsigned WORD_BITS       = 8;
   localparam int unsigned RX_FIFO_DEPTH   = 16;
   localparam logic [1:0]  MODE_THREE_WIRE = 2'h0;
   localparam logic [1:0]  MODE_SELECT_IN  = 2'h1;
   localparam int unsigned CLOCK_NS        = 10;
   localparam int unsigned SCK_HALF_NS     = 40;
   localparam int unsigned SCK_HALF_CYCLES = (SCK_HALF_NS + CLOCK_NS - 1) / CLOCK_NS;
   localparam logic [3:0]  SCK_DIV_LAST    = 4'(SCK_HALF_CYCLES - 1);
   localparam logic [2:0]  LAST_BIT        = 3'h7;

   typedef struct packed {
      logic       sck_meta;
      logic       sck_sync;
      logic       sck_prev;
      logic       mosi_meta;
      logic       mosi_sync;
      logic       miso_meta;
      logic       miso_sync;
      logic       sel_meta;
      logic       sel_sync;
      logic       sel_prev;
      logic       port_en;
      logic       master_en;
      logic       fault;
      logic       done;
      logic       overrun;
      logic [7:0] shift;
      logic       sample;
      logic [2:0] count;
      logic       busy;
      logic [3:0] div;
      logic       sck;
      logic [7:0] tx_buf;
      logic       tx_full;
      logic       loaded;
      logic       sel_drive;
      logic       push;
      logic [7:0] rx_byte;
   } port_state_t;
endpackage : spi_port_pkg

// [tb.sv]
// Self-checking bench for the SPI port pins and select modes
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic            clock, rst, cfg_write, cfg_pe, cfg_me, clr_fault, clr_done;
   logic            tx_valid, rx_ready;
   logic      [1:0] mode;
   logic      [7:0] tx_data;
   wire logic       pe, me, fault, done, tx_ready, rx_valid, mosi_o, mosi_oe;
   wire logic       miso_o, miso_oe, sck_o, sck_oe, sel_o, sel_oe, routed;
   wire logic [7:0] rx_data;
   wire logic       ovr;
   wire logic       p_mosi, p_miso, p_sck, p_sel;
   wire logic       mosi_w = mosi_oe ? mosi_o : p_mosi;
   wire logic       miso_w = miso_oe ? miso_o : p_miso;
   wire logic       sck_w  = sck_oe ? sck_o : p_sck;
   wire logic       sel_w  = sel_oe ? sel_o : p_sel;
   int              err_count, compares;

   spi_port spi_port_i (
      .clock, .rst, .select_pin_mode(mode), .cfg_write, .cfg_port_enable(cfg_pe),
      .cfg_master_enable(cfg_me), .port_enable_bit(pe), .master_enable_bit(me),
      .mode_fault_flag(fault), .clear_mode_fault(clr_fault), .transfer_done_flag(done),
      .clear_transfer_done(clr_done), .rx_overrun_flag(ovr), .clear_rx_overrun(1'b0),
      .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data,
      .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe, .miso_in(miso_w), .miso_out(miso_o),
      .miso_oe, .sck_in(sck_w), .sck_out(sck_o), .sck_oe, .select_in(sel_w),
      .select_out(sel_o), .select_oe(sel_oe), .select_routed(routed));
   spi_peer spi_peer_i (.sck(p_sck), .mosi(p_mosi), .sel(p_sel), .miso(p_miso),
      .sck_line(sck_w), .mosi_line(mosi_w), .miso_line(miso_w));

   always #5 clock = ~clock;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic cfg(input logic p, input logic m);
      @(negedge clock) {cfg_pe, cfg_me, cfg_write} = {p, m, 1'b1};
      @(negedge clock) cfg_write = 1'b0;
   endtask : cfg
   task automatic send(input logic [7:0] b);
      @(negedge clock) {tx_valid, tx_data} = {1'b1, b};
      for (int i = 0; i < 50 && tx_ready !== 1'b1; i++) @(negedge clock);
      @(negedge clock) tx_valid = 1'b0;
   endtask : send
   // Waits for the byte, clears the flag, pops the receive stream
   task automatic fin(input logic [7:0] exp);
      for (int i = 0; i < 300 && done !== 1'b1; i++) @(negedge clock);
      check(done, 1'b1);
      clr_done = 1'b1;
      @(negedge clock) clr_done = 1'b0;
      for (int i = 0; i < 9 && rx_valid !== 1'b1; i++) @(negedge clock);
      check(rx_data, exp);
      rx_ready = 1'b1;
      @(negedge clock) rx_ready = 1'b0;
   endtask : fin
   task automatic report_and_stop();
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      err_count++;
      $display("watchdog expired");
      report_and_stop();
   end
   initial begin
      {clock, cfg_write, cfg_pe, cfg_me, clr_fault, clr_done, tx_valid, rx_ready} = '0;
      {mode, tx_data, err_count, compares} = '0;
      rst = 1'b1;
      repeat (20) @(negedge clock);
      rst = 1'b0;
      check({pe, me, fault, done, mosi_oe, miso_oe, sck_oe, rx_valid}, 8'h00);
      $display("reset test done");
      for (int m = 0; m < 4; m++) begin
         @(negedge clock) mode = 2'(m);
         @(negedge clock);
         check({routed, sel_oe, sel_oe & sel_o}, {m != 0, m[1], m[1] & m[0]});
      end
      $display("mode test done");
      spi_peer_i.load(8'h3c);
      mode = 2'h2;
      cfg(1'b1, 1'b1);
      check({mosi_oe, sck_oe, miso_oe, sel_w}, 8'hc);
      send(8'ha5);
      fin(8'h3c);
      check(spi_peer_i.slave_rx, 8'ha5);
      $display("master test done");
      mode = 2'h0;
      cfg(1'b1, 1'b0);
      send(8'h96);
      check(miso_oe, 1'b1);
      spi_peer_i.xfer(8'h5a, 8);
      fin(8'h5a);
      check(spi_peer_i.master_rx, 8'h96);
      $display("3-wire slave test done");
      @(negedge clock) mode = 2'h1;
      repeat (4) @(negedge clock);
      check(miso_oe, 1'b0);
      spi_peer_i.xfer(8'hff, 8);
      repeat (4) @(negedge clock);
      check(done, 1'b0);
      spi_peer_i.sel = 1'b0;
      #100 spi_peer_i.xfer(8'h00, 3);
      spi_peer_i.sel = 1'b1;
      #100 spi_peer_i.sel = 1'b0;
      #100 check(miso_oe, 1'b1);
      spi_peer_i.xfer(8'h42, 8);
      fin(8'h42);
      $display("4-wire slave test done");
      spi_peer_i.sel = 1'b1;
      repeat (3) @(negedge clock);
      cfg(1'b1, 1'b1);
      repeat (4) @(negedge clock);
      check({pe, me, fault}, 8'h6);
      spi_peer_i.sel = 1'b0;
      repeat (6) @(negedge clock);
      check({pe, me, fault, mosi_oe, miso_oe, ovr}, 8'h08);
      clr_fault = 1'b1;
      @(negedge clock) clr_fault = 1'b0;
      check(fault, 1'b0);
      $display("mode fault test done");
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
